// ===== ascp_top.sv
// Asynchronous serial port: registers, baud generator, transmitter, receiver
`timescale 1ns/1ps
`include "ascp_regs.svh"
module ascp_top #(
  parameter int DEPTH = `ASCP_QUEUE_DEPTH
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Peripheral register port, word addressed
  input wire ascp_pkg::ascp_word_t bus_addr_i,
  input wire ascp_pkg::ascp_word_t bus_wdata_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  output ascp_pkg::ascp_word_t bus_rdata_o,
  // Serial link
  input wire logic serial_rx_pin_i,
  output logic serial_tx_pin_o,
  // Interrupt requests
  output logic tx_int_o,
  output logic rx_int_o
);
  import ascp_pkg::*;

  localparam int CW = $clog2(DEPTH + 1);

  //----------------------------------------------------------------------------
  // Helpers
  //----------------------------------------------------------------------------

  // Parity bit that makes the frame even (or odd) over the used data bits
  function automatic logic frame_parity(input ascp_byte_t d, input logic [2:0] lm1,
                                        input logic even);
    ascp_byte_t mask;
    mask = 8'hFF >> (3'h7 - lm1);
    return even ? ^(d & mask) : ~^(d & mask);
  endfunction : frame_parity

  // Full sixteen-bit word match, as only word accesses are decoded
  function automatic logic hit(input ascp_word_t a, input ascp_word_t reg_addr);
    return a == reg_addr;
  endfunction : hit

  //----------------------------------------------------------------------------
  // Register storage and decode
  //----------------------------------------------------------------------------

  ascp_byte_t ccr_r;
  ascp_byte_t ctl1_r;
  ascp_byte_t baud_hi_r;
  ascp_byte_t baud_lo_r;
  ascp_byte_t pri_r;
  logic tx_ie_r;
  logic rx_ie_r;
  logic qen_r;
  ascp_word_t rdata_r;

  // Write strobes, full word address compare from the 7050h base
  wire wr_ccr = bus_wr_i && hit(bus_addr_i, `ASCP_ADDR_CCR);
  wire wr_ctl1 = bus_wr_i && hit(bus_addr_i, `ASCP_ADDR_CTL1);
  wire wr_bh = bus_wr_i && hit(bus_addr_i, `ASCP_ADDR_BAUDH);
  wire wr_bl = bus_wr_i && hit(bus_addr_i, `ASCP_ADDR_BAUDL);
  wire wr_ctl2 = bus_wr_i && hit(bus_addr_i, `ASCP_ADDR_CTL2);
  wire wr_txbuf = bus_wr_i && hit(bus_addr_i, `ASCP_ADDR_TXBUF);
  wire wr_txqc = bus_wr_i && hit(bus_addr_i, `ASCP_ADDR_TXQC);
  wire wr_rxqc = bus_wr_i && hit(bus_addr_i, `ASCP_ADDR_RXQC);
  wire wr_qgc = bus_wr_i && hit(bus_addr_i, `ASCP_ADDR_QGC);
  wire wr_pri = bus_wr_i && hit(bus_addr_i, `ASCP_ADDR_PRI);
  wire rd_rxbuf = bus_rd_i && hit(bus_addr_i, `ASCP_ADDR_RXBUF);

  // Only the low byte is ever taken from the bus
  wire [7:0] wbyte = bus_wdata_i[7:0];
  wire clr_flags = wr_ctl1 && wbyte[`ASCP_CTL1_CLRFLG];
  wire txq_flush = wr_txqc && wbyte[`ASCP_QC_FLUSH];
  wire rxq_flush = wr_rxqc && wbyte[`ASCP_QC_FLUSH];

  // Frame format and control fields
  wire [2:0] len_m1 = ccr_r[2:0];
  wire addr_mode = ccr_r[`ASCP_CCR_ADDRMODE];
  wire par_en = ccr_r[`ASCP_CCR_PAREN];
  wire par_even = ccr_r[`ASCP_CCR_PAREVEN];
  wire two_stop = ccr_r[`ASCP_CCR_TWOSTOP];
  wire rx_en = ctl1_r[`ASCP_CTL1_RXEN];
  wire tx_en = ctl1_r[`ASCP_CTL1_TXEN];
  wire sleep = ctl1_r[`ASCP_CTL1_SLEEP];
  wire tx_wake = ctl1_r[`ASCP_CTL1_TXWAKE];

  //----------------------------------------------------------------------------
  // Queues in front of the single buffers
  //----------------------------------------------------------------------------

  ascp_fifo_if #(.W(8), .CW(CW)) txq ();
  ascp_fifo_if #(.W(8), .CW(CW)) rxq ();

  ascp_fifo #(.WIDTH(8), .DEPTH(DEPTH), .CW(CW)) u_txq
  (
    .ref_clk_i (ref_clk_i),
    .rst_i (rst_i),
    .q (txq)
  );

  ascp_fifo #(.WIDTH(8), .DEPTH(DEPTH), .CW(CW)) u_rxq
  (
    .ref_clk_i (ref_clk_i),
    .rst_i (rst_i),
    .q (rxq)
  );

  // With queues off the queue acts as a one-deep buffer beside the shifter
  wire tx_free = qen_r ? txq.in_ready : (txq.count == '0);
  wire rx_room = qen_r ? rxq.in_ready : (rxq.count == '0);
  wire rx_ready = rxq.out_valid;

  // A write while the buffer is taken is dropped; software polls the free flag
  assign txq.in_valid = wr_txbuf && tx_free;
  assign txq.in_data = wbyte;
  assign txq.clr = txq_flush;
  assign rxq.out_ready = rd_rxbuf;
  assign rxq.clr = rxq_flush;

  //----------------------------------------------------------------------------
  // Baud generator
  //----------------------------------------------------------------------------

  logic [15:0] div_cnt_r;
  logic tick_r;

  // Eight ticks a bit; a zero divider is treated as one, giving clock/16
  wire [15:0] baud_divider_value = {baud_hi_r, baud_lo_r};
  wire [15:0] tick_top = (baud_divider_value == 16'h0000) ? 16'h0001 : baud_divider_value;

  // Tick every tick_top+1 clocks
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i || div_cnt_r >= tick_top)
      div_cnt_r <= 16'h0000;
    else
      div_cnt_r <= div_cnt_r + 16'h0001;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      tick_r <= 1'b0;
    else
      tick_r <= (div_cnt_r >= tick_top);
  end

  //----------------------------------------------------------------------------
  // Receiver
  //----------------------------------------------------------------------------

  logic rx_s1_r;
  logic rx_s2_r;
  logic rx_prev_r;
  ascp_state_t rx_st_r;
  logic [2:0] rx_ph_r;
  logic [3:0] rx_bit_r;
  ascp_byte_t rx_sh_r;
  logic rx_ab_r;
  logic rx_pe_r;
  logic [6:0] rx_idle_r;
  logic rx_idle_seen_r;
  logic pe_f_r;
  logic oe_f_r;
  logic fe_f_r;
  logic bk_f_r;
  logic wake_f_r;

  // The pin is asynchronous: two flops before any logic
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_prev_r <= 1'b1;
    end
    else
    begin
      rx_s1_r <= serial_rx_pin_i;
      rx_s2_r <= rx_s1_r;
      rx_prev_r <= rx_s2_r;
    end
  end

  // Mid-bit sample and end-of-bit strobes
  wire rx_fall = rx_prev_r && !rx_s2_r;
  wire rx_smp = tick_r && (rx_ph_r == `ASCP_SAMPLE_TICK);
  wire rx_end = tick_r && (rx_ph_r == `ASCP_LAST_TICK);
  wire rx_last_data = (rx_bit_r[2:0] == len_m1);
  wire [7:0] rx_char = rx_sh_r >> (3'h7 - len_m1);
  wire rx_done = (rx_st_r == ST_STOP) && rx_smp;
  wire rx_exp_par = frame_parity(rx_char, len_m1, par_even);

  // Sleeping receivers take only address characters
  wire rx_is_addr = addr_mode ? rx_ab_r : rx_idle_seen_r;
  wire rx_accept = rx_done && (!sleep || rx_is_addr);
  wire rx_ovr = rx_accept && !rx_room;
  wire rx_fe = rx_done && !rx_s2_r;
  wire rx_brk = rx_fe && (rx_char == 8'h00) && !rx_ab_r;

  assign rxq.in_valid = rx_accept && rx_room;
  assign rxq.in_data = rx_char;

  // Receive state machine; disabled receiver sits idle
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i || !rx_en)
    begin
      rx_st_r <= ST_IDLE;
      rx_ph_r <= 3'h0;
      rx_bit_r <= 4'h0;
      rx_sh_r <= 8'h00;
      rx_ab_r <= 1'b0;
      rx_pe_r <= 1'b0;
    end
    else
    begin
      if (tick_r)
        rx_ph_r <= rx_ph_r + 3'h1;
      case (rx_st_r)
        ST_IDLE:
          if (rx_fall)
          begin
            rx_st_r <= ST_START;
            rx_ph_r <= 3'h0;
            rx_bit_r <= 4'h0;
            rx_ab_r <= 1'b0;
            rx_pe_r <= 1'b0;
          end
        ST_START:
          // A glitch shorter than half a bit is not a start
          if (rx_smp && rx_s2_r)
            rx_st_r <= ST_IDLE;
          else if (rx_end)
            rx_st_r <= ST_DATA;
        ST_DATA:
        begin
          if (rx_smp)
            rx_sh_r <= {rx_s2_r, rx_sh_r[7:1]};
          if (rx_end)
          begin
            rx_bit_r <= rx_bit_r + 4'h1;
            if (rx_last_data)
              rx_st_r <= addr_mode ? ST_ABIT : (par_en ? ST_PAR : ST_STOP);
          end
        end
        ST_ABIT:
        begin
          if (rx_smp)
            rx_ab_r <= rx_s2_r;
          if (rx_end)
            rx_st_r <= par_en ? ST_PAR : ST_STOP;
        end
        ST_PAR:
        begin
          if (rx_smp)
            rx_pe_r <= (rx_s2_r != rx_exp_par);
          if (rx_end)
            rx_st_r <= ST_STOP;
        end
        ST_STOP:
          // Leave at mid stop bit so the next start edge is not missed
          if (rx_smp)
            rx_st_r <= ST_IDLE;
        default:
          rx_st_r <= ST_IDLE;
      endcase
    end
  end

  // Idle-line timer: ten quiet bits before a start mark an address block
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      rx_idle_r <= 7'h00;
      rx_idle_seen_r <= 1'b0;
    end
    else if (rx_st_r == ST_IDLE && rx_fall)
    begin
      rx_idle_seen_r <= (rx_idle_r >= `ASCP_IDLE_TICKS);
      rx_idle_r <= 7'h00;
    end
    else if (rx_st_r == ST_IDLE && tick_r && rx_s2_r && rx_idle_r < `ASCP_IDLE_TICKS)
      rx_idle_r <= rx_idle_r + 7'h01;
    else if (rx_st_r != ST_IDLE)
      rx_idle_r <= 7'h00;
  end

  // Sticky error flags; a new event wins over a clear in the same cycle
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      pe_f_r <= 1'b0;
      oe_f_r <= 1'b0;
      fe_f_r <= 1'b0;
      bk_f_r <= 1'b0;
      wake_f_r <= 1'b0;
    end
    else
    begin
      pe_f_r <= (rx_done && par_en && rx_pe_r) || (pe_f_r && !clr_flags);
      oe_f_r <= rx_ovr || (oe_f_r && !clr_flags);
      fe_f_r <= rx_fe || (fe_f_r && !clr_flags);
      bk_f_r <= rx_brk || (bk_f_r && !clr_flags);
      wake_f_r <= (rx_accept && rx_is_addr) || (wake_f_r && !clr_flags);
    end
  end

  wire rx_err = pe_f_r | oe_f_r | fe_f_r | bk_f_r;

  //----------------------------------------------------------------------------
  // Transmitter
  //----------------------------------------------------------------------------

  ascp_state_t tx_st_r;
  logic [2:0] tx_ph_r;
  logic [3:0] tx_bit_r;
  ascp_byte_t tx_sh_r;
  logic tx_ab_r;
  logic tx_par_r;
  logic tx_pin_r;
  logic tx_line;

  wire tx_end = tick_r && (tx_ph_r == `ASCP_LAST_TICK);
  wire tx_load = (tx_st_r == ST_IDLE) && tick_r && tx_en && txq.out_valid;
  wire tx_empty = (tx_st_r == ST_IDLE);

  // Shifter drains the buffer only when it is empty, which back-pressures writes
  assign txq.out_ready = tx_load;

  // Line level for the current frame position
  always_comb
  begin
    case (tx_st_r)
      ST_START: tx_line = 1'b0;
      ST_DATA: tx_line = tx_sh_r[0];
      ST_ABIT: tx_line = tx_ab_r;
      ST_PAR: tx_line = tx_par_r;
      default: tx_line = 1'b1;
    endcase
  end

  // Transmit state machine
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      tx_st_r <= ST_IDLE;
      tx_ph_r <= 3'h0;
      tx_bit_r <= 4'h0;
      tx_sh_r <= 8'h00;
      tx_ab_r <= 1'b0;
      tx_par_r <= 1'b0;
    end
    else
    begin
      if (tick_r)
        tx_ph_r <= tx_ph_r + 3'h1;
      case (tx_st_r)
        ST_IDLE:
          if (tx_load)
          begin
            tx_ph_r <= 3'h0;
            tx_bit_r <= 4'h0;
            tx_sh_r <= txq.out_data;
            tx_ab_r <= tx_wake;
            tx_par_r <= frame_parity(txq.out_data, len_m1, par_even);
            // Idle-line address: eleven idle bits first
            tx_st_r <= (!addr_mode && tx_wake) ? ST_WAKE : ST_START;
          end
        ST_WAKE:
          if (tx_end)
          begin
            tx_bit_r <= tx_bit_r + 4'h1;
            if (tx_bit_r == `ASCP_WAKE_BITS - 4'h1)
            begin
              tx_bit_r <= 4'h0;
              tx_st_r <= ST_START;
            end
          end
        ST_START:
          if (tx_end)
            tx_st_r <= ST_DATA;
        ST_DATA:
          if (tx_end)
          begin
            tx_sh_r <= {1'b0, tx_sh_r[7:1]};
            tx_bit_r <= tx_bit_r + 4'h1;
            if (tx_bit_r[2:0] == len_m1)
              tx_st_r <= addr_mode ? ST_ABIT : (par_en ? ST_PAR : ST_STOP);
          end
        ST_ABIT:
          if (tx_end)
            tx_st_r <= par_en ? ST_PAR : ST_STOP;
        ST_PAR:
          if (tx_end)
            tx_st_r <= ST_STOP;
        ST_STOP:
          if (tx_end)
            tx_st_r <= two_stop ? ST_STOP2 : ST_IDLE;
        ST_STOP2:
          if (tx_end)
            tx_st_r <= ST_IDLE;
        default:
          tx_st_r <= ST_IDLE;
      endcase
    end
  end

  // Registered pin so the output never glitches between states
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      tx_pin_r <= 1'b1;
    else
      tx_pin_r <= tx_line;
  end

  //----------------------------------------------------------------------------
  // Control register writes
  //----------------------------------------------------------------------------

  // Plain storage; the wake bit is consumed by the character it marks
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      ccr_r <= `ASCP_CCR_RST;
      ctl1_r <= `ASCP_CTL1_RST;
      baud_hi_r <= `ASCP_BAUD_RST;
      baud_lo_r <= `ASCP_BAUD_RST;
      pri_r <= 8'h00;
      tx_ie_r <= 1'b0;
      rx_ie_r <= 1'b0;
      qen_r <= 1'b0;
    end
    else
    begin
      if (wr_ccr)
        ccr_r <= wbyte & 8'hEF;
      if (wr_ctl1)
        ctl1_r <= wbyte & `ASCP_CTL1_MASK;
      else if (tx_load)
        ctl1_r[`ASCP_CTL1_TXWAKE] <= 1'b0;
      if (wr_bh)
        baud_hi_r <= wbyte;
      if (wr_bl)
        baud_lo_r <= wbyte;
      if (wr_ctl2)
      begin
        tx_ie_r <= wbyte[0];
        rx_ie_r <= wbyte[1];
      end
      if (wr_qgc)
        qen_r <= wbyte[`ASCP_QGC_EN];
      if (wr_pri)
        pri_r <= wbyte;
    end
  end

  //----------------------------------------------------------------------------
  // Read path
  //----------------------------------------------------------------------------

  ascp_byte_t rd_byte;

  // Status views; unmapped words read zero
  always_comb
  begin
    case (bus_addr_i)
      `ASCP_ADDR_CCR: rd_byte = ccr_r;
      `ASCP_ADDR_CTL1: rd_byte = ctl1_r;
      `ASCP_ADDR_BAUDH: rd_byte = baud_hi_r;
      `ASCP_ADDR_BAUDL: rd_byte = baud_lo_r;
      `ASCP_ADDR_CTL2: rd_byte = {tx_free, tx_empty, 4'h0, rx_ie_r, tx_ie_r};
      `ASCP_ADDR_RXST: rd_byte = {rx_err, rx_ready, bk_f_r, fe_f_r, oe_f_r, pe_f_r,
                                  wake_f_r, 1'b0};
      `ASCP_ADDR_RXDBG: rd_byte = rxq.out_data;
      `ASCP_ADDR_RXBUF: rd_byte = rxq.out_data;
      `ASCP_ADDR_TXQC: rd_byte = 8'(txq.count);
      `ASCP_ADDR_RXQC: rd_byte = 8'(rxq.count);
      `ASCP_ADDR_QGC: rd_byte = {7'h00, qen_r};
      `ASCP_ADDR_PRI: rd_byte = pri_r;
      default: rd_byte = 8'h00;
    endcase
  end

  // Read data one cycle after the strobe, upper byte always zero
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      rdata_r <= 16'h0000;
    else if (bus_rd_i)
      rdata_r <= {8'h00, rd_byte};
  end

  //----------------------------------------------------------------------------
  // Interrupt requests and outputs
  //----------------------------------------------------------------------------

  logic tx_int_r;
  logic rx_int_r;

  // Break shares the receive enable rather than having its own
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      tx_int_r <= 1'b0;
      rx_int_r <= 1'b0;
    end
    else
    begin
      tx_int_r <= tx_ie_r && tx_free;
      rx_int_r <= rx_ie_r && (rx_ready || bk_f_r);
    end
  end

  assign bus_rdata_o = rdata_r;
  assign serial_tx_pin_o = tx_pin_r;
  assign tx_int_o = tx_int_r;
  assign rx_int_o = rx_int_r;

endmodule : ascp_top

// ===== ascp_regs.svh
// Register map, field positions, reset values and timing counts of the serial port
//------------------------------------------------------------------------------
// Operation
// - Async NRZ characters on separate pins
// - One buffered character per path, own enables
// - Transmitter and receiver run alone or together
// - Distinct break, parity, overrun, framing flags
// - Rate is clock/(8*(div+1)), or clock/16
// - Sixteen-bit divider in high and low bytes
// - Start, one-to-eight data, parity, one/two stops
// - Idle-line and address-bit wake-up schemes
// - Buffer-free flag and shifter-empty flag
// - Ready, break and summary error flags
// - Separate transmit and receive interrupt enables
// - Data in bits 7-0, upper byte zero
// - Registers decode from word address 7050h
//------------------------------------------------------------------------------
`ifndef ASCP_REGS_SVH
`define ASCP_REGS_SVH

// Word addresses
`define ASCP_ADDR_CCR 16'h7050
`define ASCP_ADDR_CTL1 16'h7051
`define ASCP_ADDR_BAUDH 16'h7052
`define ASCP_ADDR_BAUDL 16'h7053
`define ASCP_ADDR_CTL2 16'h7054
`define ASCP_ADDR_RXST 16'h7055
`define ASCP_ADDR_RXDBG 16'h7056
`define ASCP_ADDR_RXBUF 16'h7057
`define ASCP_ADDR_TXBUF 16'h7059
`define ASCP_ADDR_TXQC 16'h705A
`define ASCP_ADDR_RXQC 16'h705B
`define ASCP_ADDR_QGC 16'h705C
`define ASCP_ADDR_PRI 16'h705F

// Field positions
`define ASCP_CCR_ADDRMODE 3
`define ASCP_CCR_PAREN 5
`define ASCP_CCR_PAREVEN 6
`define ASCP_CCR_TWOSTOP 7
`define ASCP_CTL1_RXEN 0
`define ASCP_CTL1_TXEN 1
`define ASCP_CTL1_SLEEP 2
`define ASCP_CTL1_TXWAKE 3
`define ASCP_CTL1_CLRFLG 5
`define ASCP_QC_FLUSH 5
`define ASCP_QGC_EN 0

// Reset values
`define ASCP_CCR_RST 8'h07
`define ASCP_CTL1_RST 8'h00
`define ASCP_CTL1_MASK 8'h0F
`define ASCP_BAUD_RST 8'h00

// Timing counts
`define ASCP_TICKS_PER_BIT 8
`define ASCP_SAMPLE_TICK 3'h3
`define ASCP_LAST_TICK 3'h7
`define ASCP_IDLE_TICKS 7'h50
`define ASCP_WAKE_BITS 4'hB
`define ASCP_QUEUE_DEPTH 16

`endif

// ===== ascp_pkg.sv
// Types shared by the serial port modules
package ascp_pkg;

  typedef logic [15:0] ascp_word_t;
  typedef logic [7:0] ascp_byte_t;

  // Frame position, Gray coded along the usual path
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'h0,
    ST_START = 3'h1,
    ST_DATA = 3'h3,
    ST_ABIT = 3'h2,
    ST_PAR = 3'h6,
    ST_STOP = 3'h7,
    ST_STOP2 = 3'h5,
    ST_WAKE = 3'h4
  } ascp_state_t;

endpackage : ascp_pkg

// ===== ascp_fifo_if.sv
// Push and pop sides of one character queue
`timescale 1ns/1ps
interface ascp_fifo_if #(parameter int W = 8, parameter int CW = 5);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  logic clr;
  logic [CW-1:0] count;

  modport fifo (input in_valid, in_data, out_ready, clr,
                output in_ready, out_valid, out_data, count);
  modport user (output in_valid, in_data, out_ready, clr,
                input in_ready, out_valid, out_data, count);
endinterface : ascp_fifo_if

// ===== ascp_fifo.sv
// Flip-flop character queue; depth must be a power of two
`timescale 1ns/1ps
module ascp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int CW = 5
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Queue sides
  ascp_fifo_if.fifo q
);
  import ascp_pkg::*;

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [CW-1:0] cnt_r;
  logic push;
  logic pop;

  // Honest full and empty from the occupancy count
  assign q.in_ready = (cnt_r != CW'(DEPTH));
  assign q.out_valid = (cnt_r != '0);
  assign q.out_data = mem_r[rp_r];
  assign q.count = cnt_r;
  assign push = q.in_valid && q.in_ready;
  assign pop = q.out_valid && q.out_ready;

  // Storage needs no reset; only pointers define contents
  always_ff @(posedge ref_clk_i)
  begin
    if (push)
      mem_r[wp_r] <= q.in_data;
  end

  // Pointers and count; flush wins over traffic
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i || q.clr)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
        wp_r <= wp_r + 1'b1;
      if (pop)
        rp_r <= rp_r + 1'b1;
      if (push && !pop)
        cnt_r <= cnt_r + 1'b1;
      else if (pop && !push)
        cnt_r <= cnt_r - 1'b1;
    end
  end

endmodule : ascp_fifo

// ===== ascp_checker.sv
// Port assertions for the serial port
`timescale 1ns/1ps
module ascp_checker (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Register port
  input wire ascp_pkg::ascp_word_t bus_addr_i,
  input wire ascp_pkg::ascp_word_t bus_wdata_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  input wire ascp_pkg::ascp_word_t bus_rdata_o,
  // Serial output
  input wire logic serial_tx_pin_o
);
  import ascp_pkg::*;
  //--------------
  // Properties
  //--------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  // No bit is under 16 clocks, so any line level lasts 8 or more
  sequence low_run_s;
    !serial_tx_pin_o [*8];
  endsequence
  sequence high_run_s;
    serial_tx_pin_o [*8];
  endsequence
  // Write then read of one place on adjacent edges
  sequence wr_rd_s(ascp_word_t a);
    bus_wr_i && bus_addr_i == a ##1 bus_rd_i && bus_addr_i == a;
  endsequence
  upper_byte_zero_a: assert property (bus_rdata_o[15:8] == 8'h00)
    else $error("upper read byte not zero");
  read_data_hold_a: assert property (!bus_rd_i |=> $stable(bus_rdata_o))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (bus_rd_i && bus_addr_i == 16'h7058
    |=> bus_rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  low_bit_length_a: assert property ($fell(serial_tx_pin_o) |-> low_run_s)
    else $error("low level shorter than a bit");
  high_bit_length_a: assert property ($rose(serial_tx_pin_o) |-> high_run_s)
    else $error("high level shorter than a bit");
  format_readback_a: assert property (wr_rd_s(16'h7050)
    |=> bus_rdata_o == ($past(bus_wdata_i, 2) & 16'h00EF))
    else $error("format register readback wrong");
  enable_readback_a: assert property (wr_rd_s(16'h7051)
    |=> bus_rdata_o == ($past(bus_wdata_i, 2) & 16'h000F))
    else $error("enable register readback wrong");
  divider_readback_a: assert property (wr_rd_s(16'h7053)
    |=> bus_rdata_o == ($past(bus_wdata_i, 2) & 16'h00FF))
    else $error("divider readback wrong");
endmodule : ascp_checker

// ===== ascp_remote.sv
// Remote serial node model for the link
`timescale 1ns/1ps
module ascp_remote (
  // Link pins
  output logic rx_line_o,
  input wire logic tx_line_i
);
  //--------------
  // Frames
  //--------------
  int bit_ns = 160;
  // Line rests high between frames
  initial rx_line_o = 1'b1;
  // Start low, eight data bits LSB first, parity, stop level
  task automatic send(input logic [7:0] d, input logic pen, pb, sv);
    rx_line_o = 1'b0;
    #(bit_ns);
    for (int i = 0; i < 9 + pen; i++)
    begin
      rx_line_o = i < 8 ? d[i] : (pen && i == 8) ? pb : sv;
      #(bit_ns);
    end
    rx_line_o = 1'b1;
    #(bit_ns);
  endtask : send
  // Sample each bit mid-way after the start edge
  task automatic recv(input int n, pen, nst, output logic [7:0] d, output logic pb, st);
    d = 8'h00;
    pb = 1'b0;
    st = 1'b1;
    @(negedge tx_line_i);
    #(bit_ns / 2);
    for (int i = 0; i < n + pen + nst; i++)
    begin
      #(bit_ns);
      if (i < n)
        d[i] = tx_line_i;
      else if (pen == 1 && i == n)
        pb = tx_line_i;
      else
        st = st & tx_line_i;
    end
  endtask : recv
endmodule : ascp_remote

// ===== tb.sv
// Self-checking bench for the serial port
`timescale 1ns/1ps
module tb;
  import ascp_pkg::*;
  //--------------
  // Instances
  //--------------
  logic ref_clk_i, rst_i, bus_wr_i, bus_rd_i, rx_pin, tx_pin, tx_int, rx_int, pb, st, ep;
  ascp_word_t bus_addr_i, bus_wdata_i, rdata;
  logic [7:0] d, m, fmt [4], ch [4], dv [4], e [3];
  int n_errors = 0;
  int n_compared = 0;
  ascp_top DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus_addr_i(bus_addr_i),
    .bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
    .bus_rdata_o(rdata), .serial_rx_pin_i(rx_pin), .serial_tx_pin_o(tx_pin),
    .tx_int_o(tx_int), .rx_int_o(rx_int));
  ascp_remote rem (.rx_line_o(rx_pin), .tx_line_i(tx_pin));
  // 100 MHz clock
  initial
  begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  //--------------
  // Tasks, entered at a falling edge
  //--------------
  task automatic check(input string what, input ascp_word_t seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input ascp_word_t a, v);
    bus_addr_i = a;
    bus_wdata_i = v;
    bus_wr_i = 1'b1;
    @(negedge ref_clk_i);
    bus_wr_i = 1'b0;
    @(negedge ref_clk_i);
  endtask : wr
  // Data is registered, so look one edge after the read is taken
  task automatic rd(input ascp_word_t a, mk, exp);
    bus_addr_i = a;
    bus_rd_i = 1'b1;
    @(negedge ref_clk_i);
    bus_rd_i = 1'b0;
    @(negedge ref_clk_i);
    check($sformatf("reg %h", a), rdata & mk, exp);
  endtask : rd
  task automatic wrrd(input ascp_word_t a, v, exp);
    bus_addr_i = a;
    bus_wdata_i = v;
    bus_wr_i = 1'b1;
    @(negedge ref_clk_i);
    bus_wr_i = 1'b0;
    rd(a, 16'hFFFF, exp);
  endtask : wrrd
  task automatic complete_run();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run
  // Main sequence
  initial
  begin
    rst_i = 1'b1;
    bus_wr_i = 1'b0;
    bus_rd_i = 1'b0;
    bus_addr_i = 16'h0000;
    bus_wdata_i = 16'h0000;
    fmt = '{8'h07, 8'hE6, 8'h24, 8'hA0};
    ch = '{8'hC3, 8'h35, 8'h1E, 8'h01};
    dv = '{8'h01, 8'h00, 8'h02, 8'h01};
    e = '{8'h84, 8'h90, 8'hB0};
    repeat (8) @(negedge ref_clk_i);
    rst_i = 1'b0;
    rd(16'h7050, 16'hFFFF, 16'h0007);
    rd(16'h7058, 16'hFFFF, 16'h0000);
    wr(16'h7055, 16'h00FF);
    rd(16'h7055, 16'hFFFF, 16'h0000);
    wrrd(16'h7050, 16'hFF5A, 16'h004A);
    wrrd(16'h7051, 16'h0030, 16'h0000);
    wrrd(16'h7052, 16'hA5C3, 16'h00C3);
    wr(16'h7052, 16'h0000);
    wr(16'h7051, 16'h0003);
    // One to eight data bits, both parities, divider zero and above
    for (int i = 0; i < 4; i++)
    begin
      m = 8'hFF >> (3'h7 - fmt[i][2:0]);
      ep = fmt[i][5] & (^(ch[i] & m) ^ ~fmt[i][6]);
      rem.bit_ns = dv[i] == 8'h00 ? 160 : 80 * (dv[i] + 1);
      wr(16'h7050, {8'h00, fmt[i]});
      wrrd(16'h7053, {8'h00, dv[i]}, {8'h00, dv[i]});
      fork
        rem.recv(fmt[i][2:0] + 1, fmt[i][5], fmt[i][7] + 1, d, pb, st);
        wr(16'h7059, {8'hA5, ch[i]});
      join
      @(negedge ref_clk_i);
      check("data", {8'h00, d}, {8'h00, ch[i] & m});
      check("parity", {15'h0000, pb}, {15'h0000, ep});
      check("stop", {15'h0000, st}, 16'h0001);
    end
    wr(16'h7050, 16'h0007);
    wr(16'h7054, 16'h0001);
    check("tx int", {15'h0000, tx_int}, 16'h0001);
    // Second character waits in the buffer while the first shifts
    fork
      begin
        rem.recv(8, 0, 1, d, pb, st);
        check("first", {8'h00, d}, 16'h0066);
        rem.recv(8, 0, 1, d, pb, st);
        check("second", {8'h00, d}, 16'h0099);
      end
      begin
        wr(16'h7059, 16'h0066);
        repeat (20) @(negedge ref_clk_i);
        wr(16'h7059, 16'h0099);
        rd(16'h7054, 16'h00C0, 16'h0000);
      end
    join
    repeat (16) @(negedge ref_clk_i);
    wr(16'h7054, 16'h0000);
    check("tx int off", {15'h0000, tx_int}, 16'h0000);
    rd(16'h7054, 16'h00C0, 16'h00C0);
    // Receive, then overrun keeps the older character
    rem.send(8'h96, 1'b0, 1'b0, 1'b1);
    @(negedge ref_clk_i);
    rd(16'h7055, 16'h00FF, 16'h0042);
    wr(16'h7054, 16'h0002);
    check("rx int", {15'h0000, rx_int}, 16'h0001);
    rd(16'h7056, 16'hFFFF, 16'h0096);
    rd(16'h7057, 16'hFFFF, 16'h0096);
    rd(16'h7055, 16'h0040, 16'h0000);
    rem.send(8'h11, 1'b0, 1'b0, 1'b1);
    rem.send(8'h22, 1'b0, 1'b0, 1'b1);
    @(negedge ref_clk_i);
    rd(16'h7055, 16'h00C8, 16'h00C8);
    rd(16'h7057, 16'h00FF, 16'h0011);
    // Parity, framing and break faults, each cleared first
    for (int i = 0; i < 3; i++)
    begin
      wr(16'h7051, 16'h0023);
      wr(16'h7050, i == 0 ? 16'h0067 : 16'h0007);
      rem.send(i == 2 ? 8'h00 : 8'h55, i == 0, 1'b1, i == 0);
      @(negedge ref_clk_i);
      rd(16'h7055, {8'h00, e[i]}, {8'h00, e[i]});
      rd(16'h7057, 16'hFFFF, i == 2 ? 16'h0000 : 16'h0055);
    end
    wr(16'h7051, 16'h0023);
    rd(16'h7055, 16'h00BC, 16'h0000);
    complete_run();
  end
  // Cut a hang well past the expected run of about 21 us
  initial
  begin
    #400us;
    n_errors++;
    complete_run();
  end
endmodule : tb
bind ascp_top ascp_checker chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus_addr_i(bus_addr_i),
  .bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
  .bus_rdata_o(bus_rdata_o), .serial_tx_pin_o(serial_tx_pin_o));
